/* src/pdd_pkg.sv */
// pdd_pkg: constants, encodings and carrier types of the clock generator control block.
// assumes a single system clock; every other clock is a sampled level.
package pdd_pkg;

  // width of period and phase counters
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // phase steps per generated period, as a shift
  localparam int STEP_SHIFT = 3;

  // feedback source encodings
  localparam logic [1:0] FB_INTERNAL = 2'h0;
  localparam logic [1:0] FB_NET = 2'h1;
  localparam logic [1:0] FB_USER = 2'h2;

  // delay source select levels
  localparam logic SRC_PINS = 1'h1;
  localparam logic SRC_FUSES = 1'h0;

  // delay control carrier
  typedef struct packed {
    logic zero;
    logic lag;
    logic [2:0] value;
  } pdd_delay_s;

  localparam pdd_delay_s DELAY_RESET = 5'h10;

  // lock sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACQ = 3'h2,
    ST_LOCKED = 3'h4
  } pdd_lock_e;

endpackage : pdd_pkg

/* src/pdd_pll_ctrl.sv */
// pdd_pll_ctrl: digital model of a phase-locked clock generator with run-time delay control.
// assumes reference and feedback clocks are levels synchronous to CLK_SYS and far slower.
//
// Overview of operation
// - divider reset input high holds the reference input divider in reset
// - lock output goes high once generated clock has locked to reference
// - feedback comes from internal unshifted clock, its clock net, or user pin
// - unshifted output clock carries no phase shift from the generated clock
// - shifted output clock carries the configured phase shift and duty cycle
// - divided output clock passes through a secondary divider
// - source select high: delay from pins; low: delay from fuses
// - in dynamic mode zero input high forces zero delay, low applies delay
// - in dynamic mode lag/lead input high gives lag, low gives lead
// - zero status output shows the zero condition in effect
// - lag/lead status output shows the direction in effect
`timescale 1ns/1ps

module pdd_pll_ctrl #(
  parameter int IN_DIV = 1,
  parameter int SEC_DIV = 2,
  parameter int LOCK_COUNT = 4,
  parameter int LOCK_TOL = 4,
  parameter logic FUSE_ZERO = 1'h0,
  parameter logic FUSE_LAG = 1'h0,
  parameter logic [2:0] FUSE_DELAY = 3'h0,
  parameter logic [3:0] FUSE_DUTY = 4'h4
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic REFERENCE_CLOCK_IN,
  input wire logic FEEDBACK_CLOCK_IN,
  input wire logic [1:0] FEEDBACK_SELECT,
  input wire logic DIVIDER_RESET,
  input wire logic DELAY_SOURCE_SELECT,
  input wire logic DELAY_ZERO_IN,
  input wire logic DELAY_LAG_LEAD_IN,
  input wire logic [2:0] DELAY_VALUE_IN,
  output logic UNSHIFTED_CLOCK_OUT,
  output logic SHIFTED_CLOCK_OUT,
  output logic DIVIDED_CLOCK_OUT,
  output logic LOCK_STATUS_OUT,
  output logic DELAY_ZERO_STATUS_OUT,
  output logic DELAY_LAG_LEAD_STATUS_OUT,
  output logic [2:0] DELAY_VALUE_OUT
);

  localparam int W = pdd_pkg::CNT_W;

  if (IN_DIV < 1 || IN_DIV > 255 || SEC_DIV < 2 || SEC_DIV > 510 || (SEC_DIV % 2) != 0 ||
      LOCK_COUNT < 1 || LOCK_COUNT > 255 || LOCK_TOL < 0 || LOCK_TOL > 255 ||
      FUSE_DUTY == 4'h0 || FUSE_DUTY > 4'h7) begin : g_bad_params
    $error("pdd_pll_ctrl: unsupported parameter value");
  end

  localparam logic [7:0] IN_DIV_LAST = 8'(IN_DIV - 1);
  localparam logic [7:0] SEC_HALF_LAST = 8'(SEC_DIV / 2 - 1);
  localparam logic [7:0] LOCK_LAST = 8'(LOCK_COUNT - 1);
  localparam logic [W-1:0] TOL = W'(LOCK_TOL);
  localparam pdd_pkg::pdd_delay_s FUSE_CFG = '{zero: FUSE_ZERO, lag: FUSE_LAG, value: FUSE_DELAY};

  // position of a counter moved by an offset around a ring of length per
  function automatic logic [W-1:0] ring_pos(input logic [W-1:0] cnt, input logic [W-1:0] off,
                                            input logic [W-1:0] per, input logic lag);
    logic [W:0] sum;
    sum = '0;
    if (lag) begin
      ring_pos = (cnt >= off) ? cnt - off : W'({1'b0, cnt} + {1'b0, per} - {1'b0, off});
    end else begin
      sum = {1'b0, cnt} + {1'b0, off};
      ring_pos = (sum >= {1'b0, per}) ? W'(sum - {1'b0, per}) : sum[W-1:0];
    end
  endfunction : ring_pos

  // absolute difference of two counts, tested against the tolerance
  function automatic logic near(input logic [W-1:0] a, input logic [W-1:0] b);
    near = ((a >= b) ? a - b : b - a) <= TOL;
  endfunction : near

  //////////////////////////////////////////////////////////////////////////////
  // reference edge, input divider and period measurement

  logic ref_d_r, ref_d_nxt;
  logic [7:0] div_cnt_r, div_cnt_nxt;
  logic [W-1:0] per_cnt_r, per_cnt_nxt;
  logic [W-1:0] ref_per_r, ref_per_nxt;
  logic ref_tick;
  logic ref_timeout;

  always_comb begin
    ref_d_nxt = REFERENCE_CLOCK_IN;
    div_cnt_nxt = div_cnt_r;
    per_cnt_nxt = per_cnt_r;
    ref_per_nxt = ref_per_r;
    ref_tick = 1'b0;
    ref_timeout = (per_cnt_r == pdd_pkg::CNT_MAX);
    if (DIVIDER_RESET) begin
      div_cnt_nxt = 8'h00;
      per_cnt_nxt = pdd_pkg::CNT_ZERO;
    end else begin
      if (!ref_timeout && per_cnt_r != pdd_pkg::CNT_ZERO) begin
        per_cnt_nxt = per_cnt_r + pdd_pkg::CNT_ONE;
      end
      if (REFERENCE_CLOCK_IN && !ref_d_r) begin
        if (div_cnt_r >= IN_DIV_LAST) begin
          div_cnt_nxt = 8'h00;
          ref_tick = 1'b1;
          per_cnt_nxt = pdd_pkg::CNT_ONE;
          ref_per_nxt = ref_timeout ? pdd_pkg::CNT_ZERO : per_cnt_r;
        end else begin
          div_cnt_nxt = div_cnt_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ref_d_r <= 1'b0;
      div_cnt_r <= 8'h00;
      per_cnt_r <= pdd_pkg::CNT_ZERO;
      ref_per_r <= pdd_pkg::CNT_ZERO;
    end else begin
      ref_d_r <= ref_d_nxt;
      div_cnt_r <= div_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      ref_per_r <= ref_per_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // feedback selection and edge age

  logic gen_clk;
  logic fb_src;
  logic fb_d_r, fb_d_nxt;
  logic [W-1:0] fb_age_r, fb_age_nxt;

  always_comb begin
    case (FEEDBACK_SELECT)
      pdd_pkg::FB_INTERNAL: fb_src = gen_clk;
      pdd_pkg::FB_NET: fb_src = UNSHIFTED_CLOCK_OUT;
      default: fb_src = FEEDBACK_CLOCK_IN;
    endcase
    fb_d_nxt = fb_src;
    if (fb_src && !fb_d_r) begin
      fb_age_nxt = pdd_pkg::CNT_ZERO;
    end else if (fb_age_r != pdd_pkg::CNT_MAX) begin
      fb_age_nxt = fb_age_r + pdd_pkg::CNT_ONE;
    end else begin
      fb_age_nxt = fb_age_r;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      fb_d_r <= 1'b0;
      fb_age_r <= pdd_pkg::CNT_MAX;
    end else begin
      fb_d_r <= fb_d_nxt;
      fb_age_r <= fb_age_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lock sequencer and generated clock phase

  pdd_pkg::pdd_lock_e st_r, st_nxt;
  logic [7:0] good_r, good_nxt;
  logic [W-1:0] gen_per_r, gen_per_nxt;
  logic [W-1:0] gen_cnt_r, gen_cnt_nxt;
  logic tick_ok;
  logic gen_run;

  always_comb begin
    tick_ok = near(ref_per_nxt, gen_per_r) &&
              (fb_age_r <= TOL || near(fb_age_r, gen_per_r));
    gen_run = (gen_per_r > pdd_pkg::CNT_ONE);
    st_nxt = st_r;
    good_nxt = good_r;
    gen_per_nxt = gen_per_r;
    if (!gen_run || gen_cnt_r >= gen_per_r - pdd_pkg::CNT_ONE) begin
      gen_cnt_nxt = pdd_pkg::CNT_ZERO;
    end else begin
      gen_cnt_nxt = gen_cnt_r + pdd_pkg::CNT_ONE;
    end
    if (DIVIDER_RESET || ref_timeout) begin
      st_nxt = pdd_pkg::ST_IDLE;
      good_nxt = 8'h00;
    end else if (ref_tick) begin
      case (st_r)
        pdd_pkg::ST_IDLE: begin
          if (ref_per_nxt > pdd_pkg::CNT_ONE) begin
            st_nxt = pdd_pkg::ST_ACQ;
            gen_per_nxt = ref_per_nxt;
            gen_cnt_nxt = pdd_pkg::CNT_ZERO;
          end
        end
        pdd_pkg::ST_ACQ: begin
          if (tick_ok) begin
            good_nxt = good_r + 8'h01;
            if (good_r >= LOCK_LAST) begin
              st_nxt = pdd_pkg::ST_LOCKED;
            end
          end else begin
            good_nxt = 8'h00;
            gen_per_nxt = ref_per_nxt;
            gen_cnt_nxt = pdd_pkg::CNT_ZERO;
          end
        end
        pdd_pkg::ST_LOCKED: begin
          if (!tick_ok) begin
            st_nxt = pdd_pkg::ST_ACQ;
            good_nxt = 8'h00;
            gen_per_nxt = ref_per_nxt;
            gen_cnt_nxt = pdd_pkg::CNT_ZERO;
          end
        end
        default: begin
          st_nxt = pdd_pkg::ST_IDLE;
          good_nxt = 8'h00;
        end
      endcase
    end
    gen_clk = gen_run && (gen_cnt_r < (gen_per_r >> 1));
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_r <= pdd_pkg::ST_IDLE;
      good_r <= 8'h00;
      gen_per_r <= pdd_pkg::CNT_ZERO;
      gen_cnt_r <= pdd_pkg::CNT_ZERO;
    end else begin
      st_r <= st_nxt;
      good_r <= good_nxt;
      gen_per_r <= gen_per_nxt;
      gen_cnt_r <= gen_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // delay source, output clocks and status

  pdd_pkg::pdd_delay_s eff;
  pdd_pkg::pdd_delay_s dly_r, dly_nxt;
  logic [W-1:0] step;
  logic [W-1:0] offset;
  logic [W-1:0] high_len;
  logic [W-1:0] shift_pos;
  logic unsh_r, unsh_nxt;
  logic shft_r, shft_nxt;
  logic div_clk_r, div_clk_nxt;
  logic [7:0] sec_cnt_r, sec_cnt_nxt;
  logic lock_r, lock_nxt;

  always_comb begin
    if (DELAY_SOURCE_SELECT == pdd_pkg::SRC_PINS) begin
      eff.zero = DELAY_ZERO_IN;
      eff.lag = DELAY_LAG_LEAD_IN;
      eff.value = DELAY_VALUE_IN;
    end else begin
      eff = FUSE_CFG;
    end
    dly_nxt = eff;
    step = gen_per_r >> pdd_pkg::STEP_SHIFT;
    offset = eff.zero ? pdd_pkg::CNT_ZERO : W'(step * eff.value);
    high_len = W'(step * FUSE_DUTY);
    shift_pos = ring_pos(gen_cnt_r, offset, gen_per_r, eff.lag);
    unsh_nxt = gen_clk;
    shft_nxt = gen_run && (shift_pos < high_len);
    sec_cnt_nxt = sec_cnt_r;
    div_clk_nxt = div_clk_r;
    if (gen_clk && !unsh_r) begin
      if (sec_cnt_r >= SEC_HALF_LAST) begin
        sec_cnt_nxt = 8'h00;
        div_clk_nxt = !div_clk_r;
      end else begin
        sec_cnt_nxt = sec_cnt_r + 8'h01;
      end
    end
    lock_nxt = (st_nxt == pdd_pkg::ST_LOCKED);
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      dly_r <= pdd_pkg::DELAY_RESET;
      unsh_r <= 1'b0;
      shft_r <= 1'b0;
      div_clk_r <= 1'b0;
      sec_cnt_r <= 8'h00;
      lock_r <= 1'b0;
    end else begin
      dly_r <= dly_nxt;
      unsh_r <= unsh_nxt;
      shft_r <= shft_nxt;
      div_clk_r <= div_clk_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign UNSHIFTED_CLOCK_OUT = unsh_r;
  assign SHIFTED_CLOCK_OUT = shft_r;
  assign DIVIDED_CLOCK_OUT = div_clk_r;
  assign LOCK_STATUS_OUT = lock_r;
  assign DELAY_ZERO_STATUS_OUT = dly_r.zero;
  assign DELAY_LAG_LEAD_STATUS_OUT = dly_r.lag;
  assign DELAY_VALUE_OUT = dly_r.value;

endmodule : pdd_pll_ctrl

/* testbench/pdd_pll_ctrl_checker.sv */
// pdd_pll_ctrl_checker: port-level assertions for the clock generator control block.
// assumes one clock domain and the fuse parameters of the bound instance.
`timescale 1ns/1ps
module pdd_pll_ctrl_checker #(
  parameter logic FUSE_ZERO = 1'h0,
  parameter logic FUSE_LAG = 1'h0,
  parameter logic [2:0] FUSE_DELAY = 3'h0
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic REFERENCE_CLOCK_IN,
  input wire logic DIVIDER_RESET,
  input wire logic DELAY_SOURCE_SELECT,
  input wire logic DELAY_ZERO_IN,
  input wire logic DELAY_LAG_LEAD_IN,
  input wire logic [2:0] DELAY_VALUE_IN,
  input wire logic UNSHIFTED_CLOCK_OUT,
  input wire logic DIVIDED_CLOCK_OUT,
  input wire logic LOCK_STATUS_OUT,
  input wire logic DELAY_ZERO_STATUS_OUT,
  input wire logic DELAY_LAG_LEAD_STATUS_OUT,
  input wire logic [2:0] DELAY_VALUE_OUT
);
  logic [4:0] st;
  assign st = {DELAY_ZERO_STATUS_OUT, DELAY_LAG_LEAD_STATUS_OUT, DELAY_VALUE_OUT};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_zero_follow: assert property (
    DELAY_SOURCE_SELECT |=> DELAY_ZERO_STATUS_OUT == $past(DELAY_ZERO_IN))
    else $error("zero status not following pin");
  a_lag_follow: assert property (
    DELAY_SOURCE_SELECT |=> DELAY_LAG_LEAD_STATUS_OUT == $past(DELAY_LAG_LEAD_IN))
    else $error("lag status not following pin");
  a_value_follow: assert property (
    DELAY_SOURCE_SELECT |=> DELAY_VALUE_OUT == $past(DELAY_VALUE_IN))
    else $error("delay value not following pin");
  a_fuse_apply: assert property (
    !DELAY_SOURCE_SELECT |=> st == {FUSE_ZERO, FUSE_LAG, FUSE_DELAY})
    else $error("fuse setting not applied");
  a_fuse_ignore: assert property (
    !DELAY_SOURCE_SELECT && !$past(DELAY_SOURCE_SELECT) && !$past(RESET) && !$past(RESET, 2)
      |-> $stable(st))
    else $error("status moved in fuse mode");
  a_divrst_unlock: assert property (
    DIVIDER_RESET |=> !LOCK_STATUS_OUT)
    else $error("lock held during divider reset");
  a_lock_tick: assert property (
    $rose(LOCK_STATUS_OUT) |-> $past(REFERENCE_CLOCK_IN) && !$past(REFERENCE_CLOCK_IN, 2)
      && !$past(DIVIDER_RESET))
    else $error("lock rose without reference tick");
  a_div_edge: assert property (
    $changed(DIVIDED_CLOCK_OUT) |-> $changed(UNSHIFTED_CLOCK_OUT)
      || $past(UNSHIFTED_CLOCK_OUT) != $past(UNSHIFTED_CLOCK_OUT, 2))
    else $error("divided clock moved off an unshifted edge");
endmodule : pdd_pll_ctrl_checker
bind pdd_pll_ctrl pdd_pll_ctrl_checker #(.FUSE_ZERO(FUSE_ZERO), .FUSE_LAG(FUSE_LAG),
  .FUSE_DELAY(FUSE_DELAY)) chk_u (.*);

/* testbench/pdd_fabric_model.sv */
// pdd_fabric_model: user fabric making the reference clock and a looped user feedback.
// assumes the bench sets period; period 0 parks the reference low.
`timescale 1ns/1ps
module pdd_fabric_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] period,
  input wire logic loop_in,
  output logic ref_clk,
  output logic fb_clk
);
  logic [15:0] cnt_r, cnt_nxt;
  always_comb begin
    cnt_nxt = (cnt_r + 16'h0001 >= period) ? 16'h0000 : cnt_r + 16'h0001;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= 16'h0000;
      ref_clk <= 1'h0;
      fb_clk <= 1'h0;
    end else begin
      cnt_r <= cnt_nxt;
      ref_clk <= cnt_r < (period >> 1);
      fb_clk <= loop_in;
    end
  end
endmodule : pdd_fabric_model

/* testbench/pdd_pll_ctrl_test.sv */
// pdd_pll_ctrl_test: directed bench for delay controls, lock and output clocks.
// assumes the fabric model supplies reference and user feedback clocks.
`timescale 1ns/1ps
module pdd_pll_ctrl_test;
  logic clk_sys, reset, div_rst, src, ref_clk, fb_clk, unsh, shft, divd, lock;
  logic [1:0] fb_sel;
  logic [15:0] period, n;
  logic [3:0] s;
  pdd_pkg::pdd_delay_s dly_in, dly_st;
  int mismatches, num_checks;
  assign s = {~shft, shft, divd, unsh};
  pdd_pll_ctrl dut_u (.CLK_SYS(clk_sys), .RESET(reset), .REFERENCE_CLOCK_IN(ref_clk),
    .FEEDBACK_CLOCK_IN(fb_clk), .FEEDBACK_SELECT(fb_sel), .DIVIDER_RESET(div_rst),
    .DELAY_SOURCE_SELECT(src), .DELAY_ZERO_IN(dly_in.zero),
    .DELAY_LAG_LEAD_IN(dly_in.lag), .DELAY_VALUE_IN(dly_in.value),
    .UNSHIFTED_CLOCK_OUT(unsh), .SHIFTED_CLOCK_OUT(shft), .DIVIDED_CLOCK_OUT(divd),
    .LOCK_STATUS_OUT(lock), .DELAY_ZERO_STATUS_OUT(dly_st.zero),
    .DELAY_LAG_LEAD_STATUS_OUT(dly_st.lag), .DELAY_VALUE_OUT(dly_st.value));
  pdd_fabric_model fab_u (.clk_sys(clk_sys), .reset(reset), .period(period),
    .loop_in(unsh), .ref_clk(ref_clk), .fb_clk(fb_clk));
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc
  // cycles from a rise of s[a] to the next rise of s[b]
  task span(input int a, input int b, output logic [15:0] n);
    logic p;
    n = 16'h0000;
    do begin
      p = s[a];
      cyc(1);
      n++;
    end while (!(s[a] && !p) && n < 16'h03E8);
    n = 16'h0000;
    do begin
      p = s[b];
      cyc(1);
      n++;
    end while (!(s[b] && !p) && n < 16'h03E8);
  endtask : span
  task lock_up(input logic [1:0] sel);
    int k;
    fb_sel = sel;
    div_rst = 1'h1;
    cyc(3);
    div_rst = 1'h0;
    k = 0;
    while (lock !== 1'h1 && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask : lock_up
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  // run takes about 5000 cycles; ten times that is a hang
  initial begin
    #400000;
    mismatches++;
    test_done;
  end
  initial begin
    reset = 1'h1;
    div_rst = 1'h0;
    src = 1'h0;
    dly_in = 5'h00;
    fb_sel = 2'h0;
    period = 16'h0000;
    mismatches = 0;
    num_checks = 0;
    cyc(3);
    check({11'h000, dly_st}, {11'h000, pdd_pkg::DELAY_RESET});
    reset = 1'h0;
    dly_in = 5'h1F;
    cyc(2);
    check({11'h000, dly_st}, 16'h0000);
    src = 1'h1;
    for (int i = 0; i < 8; i++) begin
      dly_in = {i == 5, i[0], i[2:0]};
      cyc(2);
      check({11'h000, dly_st}, {11'h000, dly_in});
    end
    period = 16'h0040;
    for (int f = 0; f < 4; f++) begin
      lock_up(f[1:0]);
      check({15'h0000, lock}, 16'h0001);
      span(0, 0, n);
      check(n, 16'h0040);
    end
    span(1, 1, n);
    check(n, 16'h0080);
    span(2, 3, n);
    check(n, 16'h0020);
    for (int j = 0; j < 3; j++) begin
      dly_in = j == 0 ? 5'h0A : j == 1 ? 5'h02 : 5'h1A;
      cyc(130);
      span(0, 2, n);
      check(n, j == 0 ? 16'h0010 : j == 1 ? 16'h0030 : 16'h0040);
    end
    div_rst = 1'h1;
    cyc(2);
    check({15'h0000, lock}, 16'h0000);
    cyc(300);
    check({15'h0000, lock}, 16'h0000);
    div_rst = 1'h0;
    lock_up(2'h0);
    period = 16'h0064;
    cyc(300);
    check({15'h0000, lock}, 16'h0000);
    lock_up(2'h0);
    check({15'h0000, lock}, 16'h0001);
    test_done;
  end
endmodule : pdd_pll_ctrl_test
